// ---- logic/coef_ctrl_pkg.sv ----
// Constants and types for the reset and coefficient buffer swap control.
// Assumes one system clock and a frame-end pulse made on that clock.
`default_nettype none

package coef_ctrl_pkg;

  // Host port widths: the address is {page, register}.
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Pages.
  localparam logic [7:0] PAGE_CTRL  = 8'h00;
  localparam logic [7:0] PAGE_ADAPT = 8'h2C;
  localparam logic [7:0] PAGE_BUF_A = 8'h2E;
  localparam logic [7:0] PAGE_BUF_B = 8'h2F;

  // Registers within the pages.
  localparam logic [7:0] REG_RESET  = 8'h01;
  localparam logic [7:0] REG_POWER  = 8'h02;
  localparam logic [7:0] REG_MODE   = 8'h03;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SWAP   = 8'h01;

  // Field positions.
  localparam int RST_MOD_BIT  = 0;
  localparam int RST_REG_BIT  = 4;
  localparam int PDN_BIT      = 0;
  localparam int STBY_BIT     = 4;
  localparam int ADAPT_BIT    = 0;
  localparam int BLOCKED_BIT  = 0;
  localparam int SWAP_REQ_BIT = 0;
  localparam int ACTIVE_BIT   = 2;

  // Coefficient buffer geometry.
  localparam int COEF_AW    = 4;
  localparam int COEF_DEPTH = 16;

  // Reset values.
  localparam logic       PDN_RST   = 1'b0;
  localparam logic       STBY_RST  = 1'b0;
  localparam logic       ADAPT_RST = 1'b0;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // Host request carrier.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_s;

  // Which coefficient buffer feeds the processor.
  typedef enum logic {
    BUF_A = 1'b0,
    BUF_B = 1'b1
  } coef_buf_e;

endpackage

`default_nettype wire

// ---- logic/coef_ctrl.sv ----
// Register and module reset control plus double-buffered coefficient swap.
// Assumes frame_end_in is a one-cycle pulse on clk_in and the host port
// follows the one-cycle strobe protocol with read data one cycle later.
//
// What this block does
// - Two separate resets: control registers to defaults, filter and converter modules.
// - Reset requests accepted in any standby or power-down combination allowed.
// - Module-only reset in power-down is blocked and flagged instead.
// - Adaptive mode lets coefficients change while processing keeps running.
// - Swap request bit asks to exchange active and inactive buffers.
// - Swap request sampled only at frame end, exchanging buffers when set and adaptive mode is on.
// - Same frame-end step clears the swap request bit unless a host write to it lands in that cycle.
// - Active buffer is reported in a readable status bit.
`default_nettype none

module coef_ctrl
  import coef_ctrl_pkg::*;
(
  // Clock and reset.
  input  wire logic                       clk_in,
  input  wire logic                       rst_in,
  // Host register port.
  input  wire coef_ctrl_pkg::reg_req_s    host_req_in,
  output logic [coef_ctrl_pkg::DATA_W-1:0] host_rdata_out,
  // Processor side.
  input  wire logic                       frame_end_in,
  input  wire logic [coef_ctrl_pkg::COEF_AW-1:0] coef_addr_in,
  output logic [coef_ctrl_pkg::DATA_W-1:0] coef_data_out,
  output logic                            active_buf_out,
  // Power and reset controls.
  output logic                            standby_out,
  output logic                            power_down_out,
  output logic                            module_reset_out,
  output logic                            register_reset_out,
  output logic                            reset_blocked_out
);

  import coef_ctrl_pkg::*;

  // State.
  logic              power_down_r;
  logic              standby_r;
  logic              adapt_en_r;
  logic              coef_swap_request_r;
  logic              coef_swap_request_nxt;
  coef_buf_e         active_coef_buffer_flag_r;
  logic              blocked_r;
  logic              blocked_nxt;
  logic [DATA_W-1:0] coefficient_ram_a [COEF_DEPTH];
  logic [DATA_W-1:0] coefficient_ram_b [COEF_DEPTH];

  // Address decode.
  wire [7:0] page_w = host_req_in.addr[15:8];
  wire [7:0] reg_w  = host_req_in.addr[7:0];
  wire [COEF_AW-1:0] cidx_w = host_req_in.addr[COEF_AW-1:0];
  wire       ram_row_w = (reg_w[7:COEF_AW] == 4'h0);
  wire sel_reset_w  = (page_w == PAGE_CTRL) && (reg_w == REG_RESET);
  wire sel_power_w  = (page_w == PAGE_CTRL) && (reg_w == REG_POWER);
  wire sel_mode_w   = (page_w == PAGE_CTRL) && (reg_w == REG_MODE);
  wire sel_status_w = (page_w == PAGE_CTRL) && (reg_w == REG_STATUS);
  wire sel_swap_w   = (page_w == PAGE_ADAPT) && (reg_w == REG_SWAP);
  wire sel_buf_a_w  = (page_w == PAGE_BUF_A) && ram_row_w;
  wire sel_buf_b_w  = (page_w == PAGE_BUF_B) && ram_row_w;

  // Write strobes per register.
  wire wr_w        = host_req_in.wr;
  wire wr_reset_w  = wr_w && sel_reset_w;
  wire wr_power_w  = wr_w && sel_power_w;
  wire wr_mode_w   = wr_w && sel_mode_w;
  wire wr_status_w = wr_w && sel_status_w;
  wire wr_swap_w   = wr_w && sel_swap_w;

  // Reset requests. Both bits are self-clearing commands, never stored.
  wire mod_req_w = wr_reset_w && host_req_in.wdata[RST_MOD_BIT];
  wire reg_req_w = wr_reset_w && host_req_in.wdata[RST_REG_BIT];

  // A module-only reset while powered down could hang the converters, so it
  // is dropped and reported; with a register reset beside it, it proceeds.
  wire mod_bad_w = mod_req_w && !reg_req_w && power_down_r;
  wire mod_go_w  = mod_req_w && !mod_bad_w;

  // Swap handling. The request is only looked at on the frame-end pulse.
  wire swap_set_w = wr_swap_w && host_req_in.wdata[SWAP_REQ_BIT];
  wire swap_now_w = frame_end_in && coef_swap_request_r && adapt_en_r;

  // Swap request next value: a host set in the swap cycle wins over the
  // hardware clear so a fresh request is never lost.
  always_comb
  begin
    coef_swap_request_nxt = coef_swap_request_r;
    if (reg_req_w)
    begin
      coef_swap_request_nxt = 1'b0;
    end
    else if (wr_swap_w)
    begin
      coef_swap_request_nxt = host_req_in.wdata[SWAP_REQ_BIT];
    end
    else if (swap_now_w)
    begin
      coef_swap_request_nxt = 1'b0;
    end
  end

  // Blocked-reset flag: sticky, write one to clear, a new event wins.
  always_comb
  begin
    blocked_nxt = blocked_r;
    if (wr_status_w && host_req_in.wdata[BLOCKED_BIT])
    begin
      blocked_nxt = 1'b0;
    end
    if (mod_bad_w)
    begin
      blocked_nxt = 1'b1;
    end
  end

  // Read selection.
  wire [DATA_W-1:0] rd_power_w =
    {3'h0, standby_r, 3'h0, power_down_r};
  wire [DATA_W-1:0] rd_mode_w   = {7'h00, adapt_en_r};
  wire [DATA_W-1:0] rd_status_w = {7'h00, blocked_r};
  wire [DATA_W-1:0] rd_swap_w   =
    {5'h00, active_coef_buffer_flag_r, 1'b0, coef_swap_request_r};
  wire [DATA_W-1:0] rd_value_w =
    sel_power_w  ? rd_power_w :
    sel_mode_w   ? rd_mode_w :
    sel_status_w ? rd_status_w :
    sel_swap_w   ? rd_swap_w :
    sel_buf_a_w  ? coefficient_ram_a[cidx_w] :
    sel_buf_b_w  ? coefficient_ram_b[cidx_w] :
    ZERO_BYTE;

  // Control registers. A register reset returns them to their defaults;
  // the active buffer is processor state and is left alone by it.
  always_ff @(posedge clk_in)
  begin
    if (rst_in || reg_req_w)
    begin
      power_down_r <= PDN_RST;
      standby_r    <= STBY_RST;
      adapt_en_r   <= ADAPT_RST;
    end
    else
    begin
      if (wr_power_w)
      begin
        power_down_r <= host_req_in.wdata[PDN_BIT];
        standby_r    <= host_req_in.wdata[STBY_BIT];
      end
      if (wr_mode_w)
      begin
        adapt_en_r <= host_req_in.wdata[ADAPT_BIT];
      end
    end
  end

  // Request, flag and active buffer state.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      coef_swap_request_r       <= 1'b0;
      blocked_r                 <= 1'b0;
      active_coef_buffer_flag_r <= BUF_A;
    end
    else
    begin
      coef_swap_request_r <= coef_swap_request_nxt;
      blocked_r           <= blocked_nxt;
      if (swap_now_w)
      begin
        // Only the frame-end pulse moves the selector.
        active_coef_buffer_flag_r <= coef_buf_e'(~active_coef_buffer_flag_r);
      end
    end
  end

  // Coefficient storage. No reset: contents are loaded by the host.
  always_ff @(posedge clk_in)
  begin
    if (wr_w && sel_buf_a_w)
    begin
      coefficient_ram_a[cidx_w] <= host_req_in.wdata;
    end
    if (wr_w && sel_buf_b_w)
    begin
      coefficient_ram_b[cidx_w] <= host_req_in.wdata;
    end
  end

  // Processor read port. One bank is chosen per cycle from a selector that
  // only moves at frame end, so a frame never reads a mix of both. The host
  // may still write the active bank; keeping away from it is its duty.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      coef_data_out <= ZERO_BYTE;
    end
    else if (active_coef_buffer_flag_r == BUF_B)
    begin
      coef_data_out <= coefficient_ram_b[coef_addr_in];
    end
    else
    begin
      coef_data_out <= coefficient_ram_a[coef_addr_in];
    end
  end

  // Output flops. Read data stand for exactly one cycle, zero otherwise.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      host_rdata_out     <= ZERO_BYTE;
      module_reset_out   <= 1'b0;
      register_reset_out <= 1'b0;
    end
    else
    begin
      host_rdata_out     <= host_req_in.rd ? rd_value_w : ZERO_BYTE;
      module_reset_out   <= mod_go_w;
      register_reset_out <= reg_req_w;
    end
  end

  // Level outputs mirror their registers.
  assign active_buf_out    = active_coef_buffer_flag_r;
  assign standby_out       = standby_r;
  assign power_down_out    = power_down_r;
  assign reset_blocked_out = blocked_r;

  // Checks on the reset and swap behaviour.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  swap_clears_req_a: assert property (
    swap_now_w && !wr_swap_w && !reg_req_w |=> !coef_swap_request_r ##0 active_buf_out != $past(active_buf_out))
    else $error("Swap did not clear the request and flip the buffer.");

  frame_swap_flip_a: assert property (
    frame_end_in && coef_swap_request_r && adapt_en_r |=> active_buf_out != $past(active_buf_out))
    else $error("Pending swap at frame end did not exchange buffers.");

  buffer_held_a: assert property (
    !frame_end_in |=> $stable(active_buf_out))
    else $error("Active buffer moved away from a frame boundary.");

  adaptive_off_hold_a: assert property (
    frame_end_in && !adapt_en_r |=> $stable(active_buf_out))
    else $error("Buffers exchanged with adaptive mode off.");

  module_block_a: assert property (
    mod_req_w && !reg_req_w && power_down_out |=> !module_reset_out && reset_blocked_out)
    else $error("Module-only reset in power-down was not blocked.");

  module_pulse_a: assert property (
    mod_req_w && !power_down_out ##1 !mod_req_w |-> module_reset_out ##1 !module_reset_out)
    else $error("Allowed module reset did not give one pulse.");

  register_reset_a: assert property (
    reg_req_w |=> register_reset_out && !power_down_out && !standby_out && !coef_swap_request_r)
    else $error("Register reset did not restore defaults.");

  swap_request_set_a: assert property (
    swap_set_w && !reg_req_w |=> coef_swap_request_r)
    else $error("Swap request write was not held.");

  status_read_a: assert property (
    host_req_in.rd && sel_swap_w |=> host_rdata_out[ACTIVE_BIT] == $past(active_buf_out))
    else $error("Status read did not show the active buffer.");

  read_one_cycle_a: assert property (
    !host_req_in.rd |=> host_rdata_out == ZERO_BYTE)
    else $error("Read data stood outside the read answer cycle.");

  blocked_clear_a: assert property (
    wr_status_w && host_req_in.wdata[BLOCKED_BIT] && !mod_bad_w |=> !reset_blocked_out)
    else $error("Blocked flag did not clear on a write of one.");

  combined_reset_a: assert property (
    mod_req_w && reg_req_w |=> module_reset_out && register_reset_out)
    else $error("Combined reset did not pulse both outputs.");

  pending_hold_a: assert property (
    frame_end_in && !adapt_en_r && coef_swap_request_r && !wr_swap_w && !reg_req_w
      |=> coef_swap_request_r)
    else $error("Swap request dropped while adaptive mode was off.");

  host_wins_a: assert property (
    swap_now_w && wr_swap_w && !reg_req_w
      |=> coef_swap_request_r == $past(host_req_in.wdata[SWAP_REQ_BIT]))
    else $error("Host write in a swap cycle was not kept.");

  allowed_no_flag_a: assert property (
    mod_req_w && !power_down_out |=> $stable(reset_blocked_out))
    else $error("Allowed module reset changed the blocked flag.");

endmodule

`default_nettype wire

// ---- test/host_port_model.sv ----
// Host processor model that drives the coefficient control register port.
// Assumes the request carrier of coef_ctrl_pkg and a rising-edge clock.
`default_nettype none

module host_port_model
  import coef_ctrl_pkg::*;
(
  // Clock.
  input  wire logic                             clk_in,
  // Register port.
  output var  coef_ctrl_pkg::reg_req_s          req_out,
  input  wire logic [coef_ctrl_pkg::DATA_W-1:0] rdata_in
);
  timeunit 1ns;
  timeprecision 100ps;

  // The port idles from time zero so that no strobe is ever unknown.
  initial req_out = '0;

  // One-cycle write; the strobe drops at the edge that takes it.
  task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_in);
    req_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    req_out <= '0;
  endtask

  // One-cycle read; the answer stands only in the following cycle.
  task automatic read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_in);
    req_out <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    req_out <= '0;
    @(negedge clk_in);
    d = rdata_in;
  endtask
endmodule

`default_nettype wire

// ---- test/reset_and_coef_buffer_swap_tb.sv ----
// Self-checking bench for the reset and coefficient buffer swap control.
// Assumes coef_ctrl and the host model compile beforehand.
`default_nettype none

module reset_and_coef_buffer_swap_tb
  import coef_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [15:0] A_RST  = {PAGE_CTRL, REG_RESET};
  localparam logic [15:0] A_PWR  = {PAGE_CTRL, REG_POWER};
  localparam logic [15:0] A_MODE = {PAGE_CTRL, REG_MODE};
  localparam logic [15:0] A_STAT = {PAGE_CTRL, REG_STATUS};
  localparam logic [15:0] A_SWAP = {PAGE_ADAPT, REG_SWAP};
  localparam logic [15:0] A_C3   = {PAGE_BUF_A, 8'h03};
  localparam logic [15:0] B_C3   = {PAGE_BUF_B, 8'h03};

  logic              clk_in;
  logic              rst_in;
  logic              frame_end_in;
  logic [3:0]        coef_addr_in;
  reg_req_s          req;
  logic [7:0]        rdata;
  logic [7:0]        coef_data;
  logic              active_buf;
  logic              standby;
  logic              power_down;
  logic              mod_rst;
  logic              reg_rst;
  logic              blocked;
  int                errors = 0;
  int                comparisons = 0;

  coef_ctrl i_dut (.clk_in(clk_in), .rst_in(rst_in), .host_req_in(req),
    .host_rdata_out(rdata), .frame_end_in(frame_end_in), .coef_addr_in(coef_addr_in),
    .coef_data_out(coef_data), .active_buf_out(active_buf), .standby_out(standby),
    .power_down_out(power_down), .module_reset_out(mod_rst),
    .register_reset_out(reg_rst), .reset_blocked_out(blocked));

  host_port_model i_host (.clk_in(clk_in), .req_out(req), .rdata_in(rdata));

  // Free-running 40 MHz clock.
  initial
  begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    check_byte(what, {7'h00, exp}, {7'h00, got});
  endtask

  task automatic chk_reg(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host.read(a, d);
    check_byte($sformatf("reg %h", a), exp, d);
  endtask

  // A frame end pulse lasts exactly one clock.
  task automatic frame_pulse();
    @(posedge clk_in);
    frame_end_in <= 1'b1;
    @(posedge clk_in);
    frame_end_in <= 1'b0;
  endtask

  task automatic final_report();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // The tests need about 120 cycles; the margin covers a stuck design.
  initial
  begin
    #100000;
    errors++;
    final_report();
  end

  // Main sequence of tests.
  initial
  begin
    rst_in = 1'b1;
    frame_end_in = 1'b0;
    coef_addr_in = 4'h3;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    chk_reg(A_PWR, 8'h00);
    chk_reg(A_MODE, 8'h00);
    chk_reg(A_STAT, 8'h00);
    chk_reg(A_SWAP, 8'h00);
    chk_reg(16'h0005, 8'h00);
    $display("test reset values done");
    i_host.write(A_PWR, 8'h10);
    i_host.write(A_RST, 8'h01);
    @(negedge clk_in);
    check_bit("module reset", 1'b1, mod_rst);
    check_bit("register reset", 1'b0, reg_rst);
    @(negedge clk_in);
    check_bit("module reset", 1'b0, mod_rst);
    check_bit("standby", 1'b1, standby);
    check_bit("blocked", 1'b0, blocked);
    i_host.write(A_RST, 8'h10);
    @(negedge clk_in);
    check_bit("register reset", 1'b1, reg_rst);
    check_bit("module reset", 1'b0, mod_rst);
    @(negedge clk_in);
    check_bit("standby", 1'b0, standby);
    $display("test standby resets done");
    // Standby plus power-down first, then power-down alone.
    i_host.write(A_PWR, 8'h11);
    i_host.write(A_RST, 8'h01);
    @(negedge clk_in);
    check_bit("power down", 1'b1, power_down);
    check_bit("module reset", 1'b0, mod_rst);
    check_bit("blocked", 1'b1, blocked);
    chk_reg(A_STAT, 8'h01);
    chk_reg(A_PWR, 8'h11);
    i_host.write(A_STAT, 8'h01);
    chk_reg(A_STAT, 8'h00);
    i_host.write(A_RST, 8'h11);
    @(negedge clk_in);
    check_bit("module reset", 1'b1, mod_rst);
    check_bit("register reset", 1'b1, reg_rst);
    check_bit("blocked", 1'b0, blocked);
    chk_reg(A_PWR, 8'h00);
    i_host.write(A_PWR, 8'h01);
    i_host.write(A_RST, 8'h01);
    @(negedge clk_in);
    check_bit("module reset", 1'b0, mod_rst);
    check_bit("blocked", 1'b1, blocked);
    i_host.write(A_RST, 8'h10);
    @(negedge clk_in);
    check_bit("register reset", 1'b1, reg_rst);
    check_bit("blocked", 1'b1, blocked);
    chk_reg(A_PWR, 8'h00);
    i_host.write(A_STAT, 8'h01);
    chk_reg(A_STAT, 8'h00);
    $display("test power down resets done");
    // With adaptive mode off a request must wait and nothing swaps.
    i_host.write(A_C3, 8'h11);
    i_host.write(B_C3, 8'h11);
    i_host.write(A_SWAP, 8'h01);
    frame_pulse();
    @(negedge clk_in);
    check_bit("active buffer", 1'b0, active_buf);
    chk_reg(A_SWAP, 8'h01);
    i_host.write(A_SWAP, 8'h00);
    chk_reg(A_SWAP, 8'h00);
    i_host.write(A_MODE, 8'h01);
    frame_pulse();
    @(negedge clk_in);
    check_bit("active buffer", 1'b0, active_buf);
    check_byte("coefficient", 8'h11, coef_data);
    i_host.write(B_C3, 8'h22);
    i_host.write(A_SWAP, 8'h01);
    chk_reg(A_SWAP, 8'h01);
    frame_pulse();
    @(negedge clk_in);
    check_bit("active buffer", 1'b1, active_buf);
    chk_reg(A_SWAP, 8'h04);
    check_byte("coefficient", 8'h22, coef_data);
    i_host.write(A_C3, 8'h22);
    chk_reg(A_C3, 8'h22);
    i_host.write(A_C3, 8'h33);
    i_host.write(A_SWAP, 8'h01);
    frame_pulse();
    @(negedge clk_in);
    check_bit("active buffer", 1'b0, active_buf);
    chk_reg(A_SWAP, 8'h00);
    check_byte("coefficient", 8'h33, coef_data);
    i_host.write(B_C3, 8'h33);
    i_host.write(A_SWAP, 8'h01);
    // A host write landing on the swap edge keeps its own value.
    fork
      frame_pulse();
      i_host.write(A_SWAP, 8'h01);
    join
    @(negedge clk_in);
    check_bit("active buffer", 1'b1, active_buf);
    chk_reg(A_SWAP, 8'h05);
    check_byte("coefficient", 8'h33, coef_data);
    frame_pulse();
    @(negedge clk_in);
    check_bit("active buffer", 1'b0, active_buf);
    chk_reg(A_SWAP, 8'h00);
    i_host.write({PAGE_BUF_A, 8'h05}, 8'h5A);
    @(posedge clk_in);
    coef_addr_in <= 4'h5;
    repeat (2) @(negedge clk_in);
    check_byte("coefficient", 8'h5A, coef_data);
    // A register reset drops a pending request and adaptive mode.
    i_host.write(A_SWAP, 8'h01);
    i_host.write(A_RST, 8'h10);
    chk_reg(A_SWAP, 8'h00);
    chk_reg(A_MODE, 8'h00);
    frame_pulse();
    @(negedge clk_in);
    check_bit("active buffer", 1'b0, active_buf);
    $display("test buffer swap done");
    final_report();
  end
endmodule

`default_nettype wire
